// >>> verilog/nvr_defs.vh
/*
 * Constants for the dual digital resistor two-wire slave: memory map,
 * reset values, bus address and timing counts.
 * Assumes a 40 MHz system clock.
 */
`ifndef NVR_DEFS_VH
`define NVR_DEFS_VH

`define NVR_OFS_BUS_ADDR     8'h00
`define NVR_OFS_FLOAT        8'h01
`define NVR_OFS_WIPER_A      8'h02
`define NVR_OFS_WIPER_B      8'h03
`define NVR_OFS_UNLOCK_EH    8'h04
`define NVR_OFS_UNLOCK_EL    8'h05
`define NVR_OFS_UNLOCK_SH    8'h06
`define NVR_OFS_UNLOCK_SL    8'h07
`define NVR_OFS_USER_BASE    8'h10

`define NVR_RST_BUS_ADDR     8'ha0
`define NVR_RST_FLOAT        8'h00
`define NVR_RST_WIPER        8'h7f
`define NVR_RST_UNLOCK       8'hff
`define NVR_RST_USER         8'hff

`define NVR_FIXED_ADDR       8'ha2
`define NVR_FLOAT_BIT_A      0
`define NVR_FLOAT_BIT_B      1

`define NVR_CLK_HZ           40000000
`define NVR_NV_WRITE_MS      10
`define NVR_NV_WRITE_CYC     (`NVR_CLK_HZ / 1000 * `NVR_NV_WRITE_MS)
`define NVR_RECALL_CYC       5'h10

`endif

// >>> verilog/nvr_i2c_slave.v
/*
 * Two-wire slave and register bank of a dual 256-position digital
 * resistor with user nonvolatile storage, in one module.
 * Assumes scl and sda come from an outside master on pins, are not
 * aligned to sys_clk, and that sda is wired open-drain by the bench.
 */
`timescale 1ns/1ps
`include "nvr_defs.vh"

// Function
// - Two independent 256-position resistors, each with extra float state.
// - Register 01h bits 0 and 1 float resistor a and b.
// - Position 00h is minimum resistance, FFh maximum, linear between.
// - Both resistors float at power-up while stored settings are recalled.
// - Address-select low answers fixed address byte A2h.
// - Address-select high uses upper seven bits of byte 00h.
// - Protected while stored code at 06h-07h differs from entry code.
// - Protected: reads allowed, writes only to 04h-05h accepted.
// - Matching entry code opens writes to every writable location.
// - Stored code ships FFFFh; entry code resets FFFFh each power-up.
// - Repeated start is recognised exactly like a start.
// - Sda changes only while scl low; bits captured on scl rise.
// - Device drives each sent bit after the preceding scl fall.
// - Ninth bit is receiver acknowledge: zero ack, one not-ack.
// - Written bytes received msb first then acknowledged by device.
// - First byte after start is address plus direction bit.
// - Byte after write address loads the internal address counter.
// - Writes wrap within a two-byte page starting at even address.
// - No address acknowledge while a nonvolatile page write runs.
// - Address mismatch ignores the bus until the next start.
module nvr_i2c_slave (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        scl_in,
   input  wire        sda_in,
   input  wire        addr_sel_in,
   output reg         sda_out_r,
   output reg         sda_oe_r,
   output reg  [7:0]  wiper_position_a_r,
   output reg  [7:0]  wiper_position_b_r,
   output reg         float_bit_a_r,
   output reg         float_bit_b_r,
   output reg         nv_busy_r
);

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_AACK = 3'd2;
   localparam ST_WDAT = 3'd3;
   localparam ST_WACK = 3'd4;
   localparam ST_RDAT = 3'd5;
   localparam ST_RACK = 3'd6;

   localparam integer NV_CYC_INT = `NVR_NV_WRITE_CYC;
   localparam [23:0] NV_CYC     = NV_CYC_INT[23:0];
   localparam [4:0]  RECALL_CYC = `NVR_RECALL_CYC;
   localparam [7:0]  FIXED_ADDR = `NVR_FIXED_ADDR;

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   reg [1:0] scl_sync_r;
   reg [1:0] sda_sync_r;
   reg [1:0] sel_sync_r;
   reg       scl_d_r;
   reg       sda_d_r;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_sync_r <= 2'b11;
         sda_sync_r <= 2'b11;
         sel_sync_r <= 2'b00;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
         sel_sync_r <= {sel_sync_r[0], addr_sel_in};
         scl_d_r    <= scl_sync_r[1];
         sda_d_r    <= sda_sync_r[1];
      end
   end

   wire scl_s   = scl_sync_r[1];
   wire sda_s   = sda_sync_r[1];
   wire scl_re  = scl_s & ~scl_d_r;
   wire scl_fe  = ~scl_s & scl_d_r;
   wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_c  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   reg [7:0]  bus_address_byte_r;
   reg [7:0]  float_control_r;
   reg [7:0]  unlock_entry_high_r;
   reg [7:0]  unlock_entry_low_r;
   reg [7:0]  unlock_setting_high_r;
   reg [7:0]  unlock_setting_low_r;
   reg [7:0]  user_mem_r [0:15];
   reg [7:0]  wiper_a_store_r;
   reg [7:0]  wiper_b_store_r;
   reg [7:0]  addr_cnt_r;

   // Write permission of a location under the current lock state
   function wr_ok;
      input [7:0] ofs;
      input       locked;
      begin
         if (ofs == `NVR_OFS_UNLOCK_EH || ofs == `NVR_OFS_UNLOCK_EL)
            wr_ok = 1'b1;
         else if (locked)
            wr_ok = 1'b0;
         else
            wr_ok = (ofs < 8'h08) || (ofs[7:4] == 4'h1);
      end
   endfunction

   // Nonvolatile location, costs a page write
   function is_nv;
      input [7:0] ofs;
      begin
         is_nv = (ofs < 8'h04) || (ofs == `NVR_OFS_UNLOCK_SH) ||
                 (ofs == `NVR_OFS_UNLOCK_SL) || (ofs[7:4] == 4'h1);
      end
   endfunction

   wire locked = {unlock_setting_high_r, unlock_setting_low_r} !=
                 {unlock_entry_high_r, unlock_entry_low_r};

   reg [7:0] rd_byte;
   always @* begin
      case (addr_cnt_r)
         `NVR_OFS_BUS_ADDR:  rd_byte = bus_address_byte_r;
         `NVR_OFS_FLOAT:     rd_byte = float_control_r;
         `NVR_OFS_WIPER_A:   rd_byte = wiper_a_store_r;
         `NVR_OFS_WIPER_B:   rd_byte = wiper_b_store_r;
         `NVR_OFS_UNLOCK_SH: rd_byte = unlock_setting_high_r;
         `NVR_OFS_UNLOCK_SL: rd_byte = unlock_setting_low_r;
         default: begin
            if (addr_cnt_r[7:4] == 4'h1)
               rd_byte = user_mem_r[addr_cnt_r[3:0]];
            else
               rd_byte = 8'hff;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Bus state machine
   // ---------------------------------------------------------------
   reg [2:0]  state_r;
   reg [3:0]  bit_cnt_r;
   reg [7:0]  shift_r;
   reg        rd_dir_r;
   reg        first_r;
   reg        nv_dirty_r;
   reg [23:0] nv_cnt_r;
   reg [4:0]  recall_cnt_r;
   reg        recall_r;
   integer    i;

   wire [6:0] my_addr = sel_sync_r[1] ? bus_address_byte_r[7:1]
                                      : FIXED_ADDR[7:1];
   wire [7:0] rx_byte = {shift_r[6:0], sda_s};

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r               <= ST_IDLE;
         bit_cnt_r             <= 4'd0;
         shift_r               <= 8'h00;
         rd_dir_r              <= 1'b0;
         first_r               <= 1'b0;
         addr_cnt_r            <= 8'h00;
         sda_out_r             <= 1'b1;
         sda_oe_r              <= 1'b0;
         nv_dirty_r            <= 1'b0;
         nv_cnt_r              <= 24'd0;
         nv_busy_r             <= 1'b0;
         bus_address_byte_r    <= `NVR_RST_BUS_ADDR;
         float_control_r       <= `NVR_RST_FLOAT;
         wiper_a_store_r       <= `NVR_RST_WIPER;
         wiper_b_store_r       <= `NVR_RST_WIPER;
         unlock_entry_high_r   <= `NVR_RST_UNLOCK;
         unlock_entry_low_r    <= `NVR_RST_UNLOCK;
         unlock_setting_high_r <= `NVR_RST_UNLOCK;
         unlock_setting_low_r  <= `NVR_RST_UNLOCK;
         for (i = 0; i < 16; i = i + 1)
            user_mem_r[i] <= `NVR_RST_USER;
      end else begin
         // Nonvolatile page write timer
         if (nv_busy_r) begin
            if (nv_cnt_r == NV_CYC - 24'd1)
               nv_busy_r <= 1'b0;
            nv_cnt_r <= nv_cnt_r + 24'd1;
         end
         if (stop_c) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
            if (nv_dirty_r) begin
               nv_busy_r  <= 1'b1;
               nv_cnt_r   <= 24'd0;
               nv_dirty_r <= 1'b0;
            end
         end else if (start_c) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'd0;
            sda_oe_r  <= 1'b0;
            if (nv_dirty_r) begin
               nv_busy_r  <= 1'b1;
               nv_cnt_r   <= 24'd0;
               nv_dirty_r <= 1'b0;
            end
         end else begin
            case (state_r)
               ST_ADDR, ST_WDAT: begin
                  if (scl_re) begin
                     shift_r   <= rx_byte;
                     bit_cnt_r <= bit_cnt_r + 4'd1;
                  end else if (scl_fe && bit_cnt_r == 4'd8) begin
                     bit_cnt_r <= 4'd0;
                     if (state_r == ST_ADDR) begin
                        if (shift_r[7:1] == my_addr && !nv_busy_r) begin
                           rd_dir_r  <= shift_r[0];
                           first_r   <= 1'b1;
                           sda_out_r <= 1'b0;
                           sda_oe_r  <= 1'b1;
                           state_r   <= ST_AACK;
                        end else
                           state_r <= ST_IDLE;
                     end else begin
                        if (first_r)
                           addr_cnt_r <= shift_r;
                        else begin
                           if (wr_ok(addr_cnt_r, locked)) begin
                              if (is_nv(addr_cnt_r))
                                 nv_dirty_r <= 1'b1;
                              case (addr_cnt_r)
                                 8'h00: bus_address_byte_r    <= shift_r;
                                 8'h01: float_control_r       <= shift_r;
                                 8'h02: wiper_a_store_r       <= shift_r;
                                 8'h03: wiper_b_store_r       <= shift_r;
                                 8'h04: unlock_entry_high_r   <= shift_r;
                                 8'h05: unlock_entry_low_r    <= shift_r;
                                 8'h06: unlock_setting_high_r <= shift_r;
                                 8'h07: unlock_setting_low_r  <= shift_r;
                                 default:
                                    user_mem_r[addr_cnt_r[3:0]] <= shift_r;
                              endcase
                           end
                           addr_cnt_r <= {addr_cnt_r[7:1],
                                          ~addr_cnt_r[0]};
                        end
                        first_r   <= 1'b0;
                        sda_out_r <= 1'b0;
                        sda_oe_r  <= 1'b1;
                        state_r   <= ST_WACK;
                     end
                  end
               end
               ST_AACK, ST_WACK: begin
                  if (scl_fe) begin
                     if (state_r == ST_AACK && rd_dir_r) begin
                        sda_out_r <= rd_byte[7];
                        sda_oe_r  <= ~rd_byte[7];
                        shift_r   <= {rd_byte[6:0], 1'b1};
                        bit_cnt_r <= 4'd1;
                        state_r   <= ST_RDAT;
                     end else begin
                        sda_oe_r <= 1'b0;
                        state_r  <= ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  if (scl_fe) begin
                     if (bit_cnt_r == 4'd8) begin
                        sda_oe_r   <= 1'b0;
                        addr_cnt_r <= addr_cnt_r + 8'd1;
                        state_r    <= ST_RACK;
                     end else begin
                        sda_out_r <= shift_r[7];
                        sda_oe_r  <= ~shift_r[7];
                        shift_r   <= {shift_r[6:0], 1'b1};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_re) begin
                     if (sda_s)
                        state_r <= ST_IDLE;
                     else
                        state_r <= ST_AACK;
                  end
               end
               default: begin
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Resistor outputs and power-up recall
   // ---------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         recall_r           <= 1'b1;
         recall_cnt_r       <= 5'd0;
         float_bit_a_r      <= 1'b1;
         float_bit_b_r      <= 1'b1;
         wiper_position_a_r <= `NVR_RST_WIPER;
         wiper_position_b_r <= `NVR_RST_WIPER;
      end else begin
         if (recall_r) begin
            recall_cnt_r <= recall_cnt_r + 5'd1;
            if (recall_cnt_r == RECALL_CYC - 5'd1)
               recall_r <= 1'b0;
         end else begin
            float_bit_a_r <= float_control_r[`NVR_FLOAT_BIT_A];
            float_bit_b_r <= float_control_r[`NVR_FLOAT_BIT_B];
         end
         wiper_position_a_r <= wiper_a_store_r;
         wiper_position_b_r <= wiper_b_store_r;
      end
   end

endmodule // nvr_i2c_slave

// >>> verif/nvr_slave_asserts.sv
/* Checker for the two-wire resistor slave, bound to its top ports.
   Assumes one clock domain, sys_clk, with rst active high. */
`timescale 1ns/1ps
module nvr_slave_asserts (
   input wire       sys_clk,
   input wire       rst,
   input wire       scl_in,
   input wire       sda_in,
   input wire       addr_sel_in,
   input wire       sda_out_r,
   input wire       sda_oe_r,
   input wire [7:0] wiper_position_a_r,
   input wire [7:0] wiper_position_b_r,
   input wire       float_bit_a_r,
   input wire       float_bit_b_r,
   input wire       nv_busy_r
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_oe_pulls_low: assert property (sda_oe_r |-> !sda_out_r)
      else $error("sda driven high");
   chk_oe_scl_low: assert property ($changed(sda_oe_r) |->
      !scl_in && !$past(scl_in)) else $error("sda moved in scl high");
   chk_ack_held: assert property ($rose(sda_oe_r) |-> sda_oe_r [*6])
      else $error("driven bit too short");
   chk_float_recall: assert property ($fell(rst) |->
      (float_bit_a_r && float_bit_b_r) [*8]) else $error("no recall float");
   chk_wiper_reset: assert property ($fell(rst) |->
      wiper_position_a_r == 8'h7f && wiper_position_b_r == 8'h7f)
      else $error("wiper reset value");
   chk_busy_stable: assert property (nv_busy_r && $past(nv_busy_r) |->
      $stable(wiper_position_a_r) && $stable(wiper_position_b_r))
      else $error("wiper moved while busy");
   chk_busy_quiet: assert property (nv_busy_r |-> !sda_oe_r)
      else $error("ack while busy");
   chk_busy_start: assert property ($rose(nv_busy_r) |->
      $past(scl_in, 3)) else $error("busy not after stop");

   cover property ($rose(nv_busy_r));
   cover property ($rose(sda_oe_r));
   cover property ($rose(float_bit_a_r));
endmodule // nvr_slave_asserts

// >>> verif/nvr_bus_master.sv
/* Two-wire bus master model driving scl and sda.
   Assumes the bench resolves sda open-drain with a pull-up. */
`timescale 1ns/1ps
module nvr_bus_master (
   input  wire sys_clk,
   input  wire sda_in,
   output reg  scl_r,
   output reg  sda_r
);
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   initial begin
      scl_r = 1'b1; // Clock stands still outside frames
      sda_r = 1'b1;
   end
   task wt(input integer n);
      begin
         repeat (n) @(negedge sys_clk);
      end
   endtask
   task bit_io(input b, output r);
      begin
         wt(3);
         sda_r = b;
         wt(2);
         scl_r = 1'b1;
         wt(2);
         r = sda_in;
         wt(1);
         scl_r = 1'b0;
      end
   endtask
   task start;
      begin
         sda_r = 1'b1;
         wt(5);
         scl_r = 1'b1;
         wt(3);
         sda_r = 1'b0;
         wt(3);
         scl_r = 1'b0;
      end
   endtask
   task stop;
      begin
         wt(3);
         sda_r = 1'b0;
         wt(2);
         scl_r = 1'b1;
         wt(3);
         sda_r = 1'b1;
         wt(4);
      end
   endtask
   task xfer(input [7:0] wd, input ai, output [7:0] rd, output ao);
      integer i;
      reg     r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(wd[i], r);
            rd[i] = r;
         end
         bit_io(ai, ao);
      end
   endtask
endmodule // nvr_bus_master

// >>> verif/tb_nvr_i2c_slave.sv
/* Self-checking bench for the two-wire resistor slave.
   Assumes the master model and checker files are compiled first. */
`timescale 1ns/1ps
module tb_nvr_i2c_slave;
   reg        sys_clk;
   reg        rst;
   reg        addr_sel_in;
   wire       scl_w;
   wire       m_sda;
   wire       sda_w;
   wire       sda_out;
   wire       sda_oe;
   wire [7:0] wa;
   wire [7:0] wb;
   wire       fa;
   wire       fb;
   wire       busy;
   integer    n_fail;
   integer    checks_done;
   reg [7:0]  rb;
   reg        ak;

   assign sda_w = m_sda & ~sda_oe;
   always #12.5 sys_clk = ~sys_clk;

   nvr_i2c_slave u_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_w),
      .sda_in(sda_w), .addr_sel_in(addr_sel_in), .sda_out_r(sda_out),
      .sda_oe_r(sda_oe), .wiper_position_a_r(wa), .wiper_position_b_r(wb),
      .float_bit_a_r(fa), .float_bit_b_r(fb), .nv_busy_r(busy));
   nvr_bus_master u_mst (.sys_clk(sys_clk), .sda_in(sda_w),
      .scl_r(scl_w), .sda_r(m_sda));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task wr(input [7:0] dev, input [7:0] ma, input [23:0] d,
           input integer n);
      integer k;
      begin
         u_mst.start;
         u_mst.xfer(dev, 1'b1, rb, ak);
         check({7'h00, ak}, 8'h00);
         u_mst.xfer(ma, 1'b1, rb, ak);
         check({7'h00, ak}, 8'h00);
         for (k = 0; k < n; k = k + 1) begin
            u_mst.xfer(d[23 - 8 * k -: 8], 1'b1, rb, ak);
            check({7'h00, ak}, 8'h00);
         end
         u_mst.stop;
         u_mst.wt(6);
      end
   endtask
   task rd(input [7:0] dev, input [7:0] ma, input [15:0] exp);
      begin
         u_mst.start;
         u_mst.xfer(dev, 1'b1, rb, ak);
         check({7'h00, ak}, 8'h00);
         u_mst.xfer(ma, 1'b1, rb, ak);
         check({7'h00, ak}, 8'h00);
         u_mst.start;
         u_mst.xfer(dev | 8'h01, 1'b1, rb, ak);
         check({7'h00, ak}, 8'h00);
         u_mst.xfer(8'hff, 1'b0, rb, ak);
         check(rb, exp[15:8]);
         u_mst.xfer(8'hff, 1'b1, rb, ak);
         check(rb, exp[7:0]);
         u_mst.stop;
      end
   endtask
   task probe(input [7:0] dev, input e);
      begin
         u_mst.start;
         u_mst.xfer(dev, 1'b1, rb, ak);
         check({7'h00, ak}, {7'h00, e});
         u_mst.stop;
      end
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail = n_fail + 1;
      give_verdict;
   end
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      addr_sel_in = 1'b0;
      n_fail = 0;
      checks_done = 0;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check({6'h00, fa, fb}, 8'h03);
      check(wa, 8'h7f);
      u_mst.wt(20);
      check({6'h00, fa, fb}, 8'h00);
      rd(8'ha2, 8'h00, 16'ha000);
      rd(8'ha2, 8'h03, 16'h7fff);
      rd(8'ha2, 8'h08, 16'hffff);
      probe(8'ha4, 1'b1);
      wr(8'ha2, 8'h04, 24'h12_3400, 2);
      wr(8'ha2, 8'h02, 24'h00_0000, 1);
      check(wa, 8'h7f);
      wr(8'ha2, 8'h04, 24'hff_ff00, 2);
      wr(8'ha2, 8'h02, 24'h11_2233, 3);
      check(wa, 8'h33);
      check(wb, 8'h22);
      check({7'h00, busy}, 8'h01);
      probe(8'ha2, 1'b1);
      rst = 1'b1;
      u_mst.wt(4);
      rst = 1'b0;
      addr_sel_in = 1'b1;
      u_mst.wt(20);
      probe(8'ha2, 1'b1);
      probe(8'ha0, 1'b0);
      wr(8'ha0, 8'h01, 24'h03_0000, 1);
      check({6'h00, fa, fb}, 8'h03);
      give_verdict;
   end
endmodule // tb_nvr_i2c_slave

bind nvr_i2c_slave nvr_slave_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
   .scl_in(scl_in), .sda_in(sda_in), .addr_sel_in(addr_sel_in),
   .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
   .wiper_position_a_r(wiper_position_a_r),
   .wiper_position_b_r(wiper_position_b_r),
   .float_bit_a_r(float_bit_a_r), .float_bit_b_r(float_bit_b_r),
   .nv_busy_r(nv_busy_r));
